// ==== verilog/fws_flash_sequencer.sv ====
// Host-side controller that drives a parallel NOR flash and interprets its status bits.
`timescale 1ns/1ps
module fws_flash_sequencer import fws_pkg::*; (
    // Clock and reset.
    input wire logic refClk,
    input wire logic resetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt.
    output logic irq,
    // Flash pins.
    output logic [20:0] flAddr,
    input wire logic [15:0] flDqIn,
    output logic [15:0] flDqOut,
    output logic flDqOe,
    output logic flCeN,
    output logic flOeN,
    output logic flWeN,
    output logic flResetN,
    input wire logic flReadyBusyN
);
    logic [20:0] addr_q;
    logic [15:0] wdata_q, rdata_q, first_q;
    logic [EV_W-1:0] status_q, enable_q, events;
    logic pinRst_q;
    logic [31:0] prdata_q;
    fws_cyc_e cyc_q;
    fws_seq_e seq_q;
    logic [2:0] cnt_q;
    logic cycReq, cycWr, cycDone;
    logic [15:0] cycData;
    logic [11:0] gap_q;
    logic gapShort;
    logic wrEn, rdSetup, mapped, startOp;
    logic tog1Same;
    logic oneWr_q;

    // APB decode; zero wait states, unmapped offsets answer with an error.
    assign wrEn = psel && penable && pwrite;
    assign rdSetup = psel && !penable;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_STATE);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;
    assign startOp = wrEn && (paddr == REG_CTRL) && (seq_q == S_IDLE);
    assign irq = |(status_q & enable_q);

    // Read data is captured in the setup phase so the access phase sees a register.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            prdata_q <= 32'h00000000;
        end else if (rdSetup) begin
            case (paddr)
                REG_CTRL: prdata_q <= {27'h0000000, pinRst_q, 4'h0};
                REG_ADDR: prdata_q <= {11'h000, addr_q};
                REG_WDATA: prdata_q <= {16'h0000, wdata_q};
                REG_RDATA: prdata_q <= {16'h0000, rdata_q};
                REG_STATUS: prdata_q <= {29'h00000000, status_q};
                REG_ENABLE: prdata_q <= {29'h00000000, enable_q};
                REG_STATE: prdata_q <= {23'h000000, flReadyBusyN, 4'h0, seq_q};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // Software-owned configuration registers.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            addr_q <= ADDR_RST;
            wdata_q <= DATA_RST;
            enable_q <= ENABLE_RST;
            pinRst_q <= 1'b0;
        end else if (wrEn) begin
            case (paddr)
                REG_ADDR: addr_q <= pwdata[20:0];
                REG_WDATA: wdata_q <= pwdata[15:0];
                REG_ENABLE: enable_q <= pwdata[EV_W-1:0];
                REG_CTRL: pinRst_q <= pwdata[CTRL_PINRST_BIT];
                default: pinRst_q <= pinRst_q;
            endcase
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            status_q <= '0;
        end else if (wrEn && paddr == REG_CLEAR) begin
            status_q <= (status_q & ~pwdata[EV_W-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    // Bus-cycle engine: one read or write strobe per request, fixed pulse and recovery.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            cyc_q <= C_IDLE;
            cnt_q <= 3'h0;
            flCeN <= 1'b1;
            flOeN <= 1'b1;
            flWeN <= 1'b1;
            flDqOe <= 1'b0;
            flDqOut <= DATA_RST;
            flAddr <= ADDR_RST;
            rdata_q <= DATA_RST;
            cycDone <= 1'b0;
        end else begin
            cycDone <= 1'b0;
            case (cyc_q)
                C_IDLE: if (cycReq) begin
                    flAddr <= addr_q;
                    flDqOut <= cycData;
                    flDqOe <= cycWr;
                    flCeN <= 1'b0;
                    cyc_q <= C_SETUP;
                end
                C_SETUP: begin
                    flOeN <= cycWr;
                    flWeN <= !cycWr;
                    cnt_q <= cycWr ? 3'(WP_CYC - 1) : 3'(ACC_CYC - 1);
                    cyc_q <= C_PULSE;
                end
                C_PULSE: if (cnt_q == 3'h0) begin
                    // Data is taken as the strobe ends, after the full access time.
                    if (flWeN) begin
                        rdata_q <= flDqIn;
                    end
                    flOeN <= 1'b1;
                    flWeN <= 1'b1;
                    flCeN <= 1'b1;
                    cnt_q <= 3'(REC_CYC - 1);
                    cyc_q <= C_REC;
                end else begin
                    cnt_q <= cnt_q - 3'h1;
                end
                C_REC: if (cnt_q == 3'h0) begin
                    flDqOe <= 1'b0;
                    cycDone <= 1'b1;
                    cyc_q <= C_IDLE;
                end else begin
                    cnt_q <= cnt_q - 3'h1;
                end
                default: cyc_q <= C_IDLE;
            endcase
        end
    end

    // Time since the last sector command, saturating at the 50 us limit.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            gap_q <= 12'(GAP_CYC);
        end else if (seq_q == S_CMD && cycDone && !oneWr_q) begin
            // Program writes share the command state but must not restart the gap.
            gap_q <= 12'h000;
        end else if (gap_q != 12'(GAP_CYC)) begin
            gap_q <= gap_q + 12'h001;
        end
    end
    assign gapShort = gap_q < 12'(GAP_CYC);

    assign tog1Same = (first_q[DQ_TOG1] == rdata_q[DQ_TOG1]);

    // Request for the cycle engine, held until it reports done.
    always_comb begin
        cycReq = 1'b0;
        cycWr = 1'b0;
        cycData = wdata_q;
        case (seq_q)
            // A single read cycle at the held address.
            S_ONE: cycReq = !cycDone;
            S_RD1, S_RD2, S_RD3, S_RD4, S_PRE, S_POST: cycReq = !cycDone;
            S_RST: begin
                cycReq = !cycDone;
                cycWr = 1'b1;
                cycData = CMD_RESET;
            end
            S_CMD: begin
                cycReq = !cycDone;
                cycWr = 1'b1;
                // A program write sends the software word, a sector command its fixed byte.
                cycData = oneWr_q ? wdata_q : CMD_SECTOR;
            end
            default: cycReq = 1'b0;
        endcase
    end

    // Operation sequencer; events are one-cycle pulses into the sticky status.
    always_ff @(posedge refClk) begin
        if (!resetn) begin
            seq_q <= S_IDLE;
            first_q <= DATA_RST;
            oneWr_q <= 1'b0;
            events <= '0;
        end else begin
            events <= '0;
            case (seq_q)
                S_IDLE: if (startOp) begin
                    case (pwdata[CTRL_OP_LSB +: 3])
                        OP_WRITE: begin
                            oneWr_q <= 1'b1;
                            seq_q <= S_CMD;
                        end
                        OP_READ: seq_q <= S_ONE;
                        OP_POLL: seq_q <= S_RD1;
                        OP_RESET: seq_q <= S_RST;
                        OP_SECTOR: seq_q <= gapShort ? S_CMD : S_PRE;
                        default: seq_q <= S_IDLE;
                    endcase
                end
                S_ONE: if (cycDone) begin
                    events[EV_DONE] <= 1'b1;
                    seq_q <= S_IDLE;
                end
                S_RD1: if (cycDone) begin
                    first_q <= rdata_q;
                    seq_q <= S_RD2;
                end
                S_RD2: if (cycDone) begin
                    if (first_q[DQ_TOG1] == rdata_q[DQ_TOG1]) begin
                        events[EV_DONE] <= 1'b1;
                        seq_q <= S_IDLE;
                    end else if (rdata_q[DQ_TOUT]) begin
                        seq_q <= S_RD3;
                    end else begin
                        seq_q <= S_RD1;
                    end
                end
                S_RD3: if (cycDone) begin
                    first_q <= rdata_q;
                    seq_q <= S_RD4;
                end
                // The toggle may stop just as the timeout flag rises, so look once more.
                S_RD4: if (cycDone) begin
                    if (tog1Same) begin
                        events[EV_DONE] <= 1'b1;
                        seq_q <= S_IDLE;
                    end else begin
                        events[EV_FAIL] <= 1'b1;
                        seq_q <= S_RST;
                    end
                end
                S_RST: if (cycDone) begin
                    events[EV_DONE] <= 1'b1;
                    seq_q <= S_IDLE;
                end
                S_PRE: if (cycDone) begin
                    if (rdata_q[DQ_ETMR]) begin
                        events[EV_DROP] <= 1'b1;
                        seq_q <= S_IDLE;
                    end else begin
                        seq_q <= S_CMD;
                    end
                end
                S_CMD: if (cycDone) begin
                    oneWr_q <= 1'b0;
                    if (oneWr_q || gapShort) begin
                        events[EV_DONE] <= 1'b1;
                        seq_q <= S_IDLE;
                    end else begin
                        seq_q <= S_POST;
                    end
                end
                S_POST: if (cycDone) begin
                    events[rdata_q[DQ_ETMR] ? EV_DROP : EV_DONE] <= 1'b1;
                    seq_q <= S_IDLE;
                end
                default: seq_q <= S_IDLE;
            endcase
        end
    end

    assign flResetN = !pinRst_q;

    // Checks on the sequencer and the pin timing.
    default clocking cb @(posedge refClk); endclocking
    default disable iff (!resetn);

    sequence seqReadDone;
        seq_q == S_RD2 && cycDone;
    endsequence
    sequence seqStopToggle;
        seqReadDone ##0 (first_q[DQ_TOG1] == rdata_q[DQ_TOG1]);
    endsequence

    chk_toggle_stop_done: assert property (
        seqStopToggle |=> events[EV_DONE] && seq_q == S_IDLE)
        else $error("Stopped toggle did not end the poll.");
    chk_timeout_recheck: assert property (
        seqReadDone ##0 (!tog1Same && rdata_q[DQ_TOUT]) |=> seq_q == S_RD3)
        else $error("Timeout flag did not trigger a recheck.");
    chk_fail_reset_cmd: assert property (
        events[EV_FAIL] |-> seq_q == S_RST ##[1:30] (!flWeN && flDqOut == CMD_RESET))
        else $error("Failure was not followed by the reset command.");
    chk_pre_timer_drop: assert property (
        (seq_q == S_PRE && cycDone && rdata_q[DQ_ETMR]) |=> events[EV_DROP] && flWeN)
        else $error("Started erase did not refuse the sector command.");
    chk_post_timer_drop: assert property (
        (seq_q == S_POST && cycDone) |=> events[EV_DROP] == $past(rdata_q[DQ_ETMR]))
        else $error("Post-check drop flag wrong.");
    chk_fast_skip_pre: assert property (
        (startOp && pwdata[2:0] == OP_SECTOR && gapShort) |=> seq_q == S_CMD)
        else $error("Fast sector command did not skip the pre-check.");
    chk_read_access_time: assert property (
        $fell(flOeN) |-> !flOeN [*4] ##1 flOeN)
        else $error("Read strobe width differs from the access time.");
    chk_write_pulse: assert property (
        $fell(flWeN) |-> (!flWeN && flDqOe) [*2] ##1 flWeN)
        else $error("Write strobe width wrong or data not driven.");
    chk_irq_level: assert property (
        events[EV_DONE] && enable_q[EV_DONE] |=> irq)
        else $error("Enabled event did not raise the interrupt.");
endmodule // fws_flash_sequencer

// ==== verilog/fws_pkg.sv ====
// Shared constants of the flash status sequencer: register map, opcodes, timing.
package fws_pkg;
    // Register byte offsets on the APB side.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CLEAR = 8'h14;
    localparam logic [7:0] REG_ENABLE = 8'h18;
    localparam logic [7:0] REG_STATE = 8'h1C;
    // Operation codes written to the low bits of the control register.
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_POLL = 3'h3;
    localparam logic [2:0] OP_SECTOR = 3'h4;
    localparam logic [2:0] OP_RESET = 3'h5;
    // Control register fields.
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_PINRST_BIT = 4;
    // Event bits, shared by status, clear and enable registers.
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_DROP = 2;
    localparam int EV_W = 3;
    // Status bit positions on the flash data bus.
    localparam int DQ_POLL = 7;
    localparam int DQ_TOG1 = 6;
    localparam int DQ_TOUT = 5;
    localparam int DQ_ETMR = 3;
    localparam int DQ_TOG2 = 2;
    // Flash command bytes.
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_SECTOR = 16'h0030;
    // Reset values.
    localparam logic [EV_W-1:0] ENABLE_RST = 3'h0;
    localparam logic [20:0] ADDR_RST = 21'h000000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // Clock and bus-cycle timing.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int T_ACC_NS = 90;
    localparam int T_WP_NS = 35;
    localparam int T_REC_NS = 30;
    localparam int T_GAP_US = 50;
    localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_CYC = (T_GAP_US * 1000000) / CLK_PERIOD_PS;
    // Bus-cycle engine and sequencer states.
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SETUP = 2'b01,
        C_PULSE = 2'b10,
        C_REC = 2'b11
    } fws_cyc_e;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_ONE = 4'b0001,
        S_RD1 = 4'b0010,
        S_RD2 = 4'b0011,
        S_RD3 = 4'b0100,
        S_RD4 = 4'b0101,
        S_RST = 4'b0110,
        S_PRE = 4'b0111,
        S_CMD = 4'b1000,
        S_POST = 4'b1001
    } fws_seq_e;
endpackage

// ==== tb/fws_flash_model.sv ====
// Behavioural parallel NOR flash that reports program and erase status bits.
`timescale 1ns/1ps
module fws_flash_model import fws_pkg::*; #(
    parameter int PROG_CYC = 20,
    parameter int LIMIT_CYC = 200,
    parameter int WIN_CYC = 300,
    parameter int ERASE_CYC = 3000
) (
    // Clock that only times the model.
    input wire logic clk,
    // Host side pins.
    input wire logic [20:0] flAddr,
    input wire logic [15:0] flDqOut,
    input wire logic flCeN,
    input wire logic flOeN,
    input wire logic flWeN,
    input wire logic flResetN,
    // Device outputs.
    output logic [15:0] dq,
    output logic readyBusyN
);
    logic [15:0] mem [16];
    logic [15:0] rdQ = 16'h0000, wDQ = 16'h0000, pDQ = 16'h0000;
    logic [3:0] wAQ = 4'h0;
    logic [1:0] modeQ = 2'd0; // Idle, program, sector window, erase.
    logic badQ = 1'b0, toutQ = 1'b0, tog1Q = 1'b0, tog2Q = 1'b0, weQ = 1'b1, oeQ = 1'b1;
    int cntQ = 0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // Commands, timers and status words; one process keeps the ordering obvious.
    always @(posedge clk) begin
        weQ <= flWeN;
        oeQ <= flOeN;
        cntQ <= cntQ + 1;
        if (!flWeN) begin
            wAQ <= flAddr[3:0];
            wDQ <= flDqOut;
        end
        if (!flResetN) begin
            modeQ <= 2'd0;
            toutQ <= 1'b0;
        // erase ignores commands; chip erase is not decoded, so no window for it.
        end else if (!weQ && flWeN && modeQ != 2'd3) begin
            cntQ <= 0;
            if (wDQ[7:0] == CMD_RESET[7:0]) begin
                modeQ <= 2'd0;
                toutQ <= 1'b0;
            end else if (wDQ[7:0] == CMD_SECTOR[7:0] && modeQ != 2'd1) begin
                modeQ <= 2'd2;
            end else if (modeQ == 2'd0) begin
                mem[wAQ] <= mem[wAQ] & wDQ;
                pDQ <= wDQ;
                badQ <= |(wDQ & ~mem[wAQ]);
                modeQ <= 2'd1;
            end
        end else if (modeQ == 2'd1 && !badQ && cntQ == PROG_CYC) begin
            modeQ <= 2'd0;
        end else if (modeQ == 2'd1 && badQ && cntQ == LIMIT_CYC) begin
            toutQ <= 1'b1;
        end else if (modeQ == 2'd2 && cntQ == WIN_CYC) begin
            modeQ <= 2'd3;
            cntQ <= 0;
        end else if (modeQ == 2'd3 && cntQ == ERASE_CYC) begin
            foreach (mem[i]) mem[i] <= 16'hFFFF;
            modeQ <= 2'd0;
        end
        if (oeQ && !flOeN && !flCeN) begin
            if (modeQ == 2'd0) begin
                rdQ <= mem[flAddr[3:0]];
            end else begin
                rdQ <= {8'h00, (modeQ == 2'd1) ? ~pDQ[7] : 1'b0, tog1Q, toutQ, 1'b0,
                        modeQ == 2'd3, tog2Q, 2'b00};
                tog1Q <= ~tog1Q;
                if (modeQ[1]) tog2Q <= ~tog2Q;
            end
        end
    end
    assign readyBusyN = (modeQ == 2'd0);
    // A released bus shows the inverse of the last word, so stale data never passes.
    assign dq = (!flCeN && !flOeN) ? rdQ : ~rdQ;
endmodule // fws_flash_model

// ==== tb/test_flash_write_status_reporting.sv ====
// Self-checking bench of the flash status sequencer against a behavioural flash.
`timescale 1ns/1ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_flash_write_status_reporting import fws_pkg::*;;
    logic refClk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, prevRd;
    logic pready, pslverr, irq, err, flDqOe, flCeN, flOeN, flWeN, flResetN, flReadyBusyN;
    logic [20:0] flAddr;
    logic [15:0] flDqIn, flDqOut, modelDq;
    logic [2:0] en = 3'h0;
    int failCount = 0, nChecks = 0;
    typedef struct {logic [2:0] op; logic [15:0] wd; logic [2:0] st; logic [15:0] rm, rx;} fws_row_s;
    // Operation, write data, expected events, read-back mask and value.
    fws_row_s rows [9] = '{
        '{OP_WRITE, 16'h1234, 3'h1, 16'h0000, 16'h0000},
        '{OP_POLL, 16'h0000, 3'h1, 16'h0000, 16'h0000},
        '{OP_READ, 16'h0000, 3'h1, 16'hFFFF, 16'h1234},
        '{OP_WRITE, 16'h1235, 3'h1, 16'h0000, 16'h0000},
        '{OP_READ, 16'h0000, 3'h1, 16'h00A8, 16'h0080},
        '{OP_POLL, 16'h0000, 3'h3, 16'h0000, 16'h0000},
        '{OP_READ, 16'h0000, 3'h1, 16'hFFFF, 16'h1234},
        '{OP_SECTOR, 16'h0030, 3'h1, 16'h0000, 16'h0000},
        // second sector command follows at once
        '{OP_SECTOR, 16'h0030, 3'h1, 16'h0000, 16'h0000}
    };
    // Clock at 40 MHz.
    always #12.5 refClk = ~refClk;
    // The bus is resolved here: the controller wins while it drives.
    assign flDqIn = flDqOe ? flDqOut : modelDq;
    fws_flash_sequencer dut (.refClk(refClk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .flAddr(flAddr), .flDqIn(flDqIn), .flDqOut(flDqOut),
        .flDqOe(flDqOe), .flCeN(flCeN), .flOeN(flOeN), .flWeN(flWeN), .flResetN(flResetN),
        .flReadyBusyN(flReadyBusyN));
    fws_flash_model flash (.clk(refClk), .flAddr(flAddr), .flDqOut(flDqOut), .flCeN(flCeN),
        .flOeN(flOeN), .flWeN(flWeN), .flResetN(flResetN), .dq(modelDq),
        .readyBusyN(flReadyBusyN));
    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up(input bit hung);
        if (hung) failCount++;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge refClk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge refClk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge refClk);
            if (pready === 1'b1) break;
        end
        if (i == 20) wrap_up(1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Starts an operation, waits for its final event, checks and clears the events.
    task automatic run_op(input logic [2:0] op, input logic [2:0] expSt);
        int i;
        apb(1'b1, REG_CTRL, {29'h0, op});
        for (i = 0; i < 4000; i++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[0] === 1'b1 || rd[2] === 1'b1) break;
        end
        if (i == 4000) wrap_up(1'b1);
        `CHK(rd[2:0], expSt)
        `CHK(irq, |(expSt & en))
        apb(1'b1, REG_CLEAR, 32'h7);
        // The clear lands at the edge that ends the transfer, so look half a cycle later.
        @(negedge refClk);
        `CHK(irq, 1'b0)
    endtask
    // Resets the controller and checks the idle pins and register reset values.
    task automatic check_reset();
        resetn <= 1'b0;
        repeat (10) @(posedge refClk);
        resetn <= 1'b1;
        `CHK({flCeN, flWeN, flOeN, flDqOe, flResetN, irq}, 6'b111010)
        apb(1'b0, REG_ENABLE, 32'h0);
        `CHK(rd[2:0], ENABLE_RST)
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h0)
        apb(1'b0, REG_ADDR, 32'h0);
        `CHK(rd[20:0], ADDR_RST)
        apb(1'b0, REG_WDATA, 32'h0);
        `CHK(rd[15:0], DATA_RST)
        apb(1'b0, REG_STATE, 32'h0);
        `CHK(rd[8:0], 9'h100)
        $display("reset test done");
    endtask
    // Main sequence: reset, the table of operations, then the awkward cases.
    initial begin
        check_reset();
        // status is always read at the program address
        apb(1'b1, REG_ADDR, 32'h1);
        en = 3'h7;
        apb(1'b1, REG_ENABLE, {29'h0, en});
        foreach (rows[k]) begin
            apb(1'b1, REG_WDATA, {16'h0, rows[k].wd});
            run_op(rows[k].op, rows[k].st);
            apb(1'b0, REG_RDATA, 32'h0);
            `CHK(rd[15:0] & rows[k].rm, rows[k].rx)
            $display("row test %0d done", k);
        end
        // The window has long run out, so erase is underway.
        repeat (2100) @(posedge refClk);
        run_op(OP_READ, 3'h1);
        apb(1'b0, REG_RDATA, 32'h0);
        prevRd = rd;
        `CHK({rd[7], rd[5], rd[3]}, 3'b001)
        run_op(OP_READ, 3'h1);
        apb(1'b0, REG_RDATA, 32'h0);
        `CHK({rd[6], rd[2]}, ~{prevRd[6], prevRd[2]})
        // A late sector command is dropped and its event is masked.
        en = 3'h3;
        apb(1'b1, REG_ENABLE, {29'h0, en});
        run_op(OP_SECTOR, 3'h4);
        apb(1'b0, REG_STATE, 32'h0);
        `CHK(rd[8], 1'b0)
        run_op(OP_POLL, 3'h1);
        run_op(OP_READ, 3'h1);
        apb(1'b0, REG_RDATA, 32'h0);
        `CHK(rd[15:0], 16'hFFFF)
        $display("erase test done");
        // Unmapped offset and the flash reset pin.
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, REG_CTRL, 32'h10);
        @(negedge refClk);
        `CHK(flResetN, 1'b0)
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[4], 1'b1)
        apb(1'b0, REG_STATE, 32'h0);
        `CHK(rd[8], 1'b1)
        apb(1'b1, REG_CTRL, 32'h0);
        run_op(OP_RESET, 3'h1);
        $display("pin test done");
        check_reset();
        wrap_up(1'b0);
    end
endmodule // test_flash_write_status_reporting
